// File: hdl/afo_serial_framer.sv
// serial output framer: coding, power modes, DDR lanes, frame clock
`timescale 1ns/1ps
`default_nettype none
module afo_serial_framer #(
   parameter int CHANNELS   = afo_pkg::CHANNELS,
   parameter int SAMPLE_MHZ = afo_pkg::CLK_SYS_MHZ
) (
   // sample clock domain
   input  wire logic                    clk_sys,
   input  wire logic                    reset_n,
   // link clock domain
   input  wire logic                    clk_link,
   // converted samples, twos complement
   input  wire logic [CHANNELS*14-1:0]  sampleIn,
   input  wire logic [CHANNELS-1:0]     posOverrange,
   input  wire logic [CHANNELS-1:0]     negOverrange,
   // control settings
   input  wire logic                    power_down_pin,
   input  wire logic                    powerDownCmd,
   input  wire logic                    standbyCmd,
   input  wire logic                    offsetBinary,
   input  wire logic                    lsbFirst,
   input  wire logic                    shortFrame,
   input  wire logic                    oneLaneMode,
   input  wire logic                    reducedSwingCmd,
   input  wire logic                    duty_cycle_stabilizer,
   input  wire logic                    clockRateChange,
   // register port
   input  wire logic                    regWrite,
   input  wire logic [7:0]              regAddr,
   input  wire logic [7:0]              regWrData,
   output logic      [7:0]              regRdData,
   // status
   output logic                         convActive,
   output logic                         refPowered,
   output logic                         dutyRegenActive,
   output logic                         dataSettling,
   output logic                         reducedSwing,
   output logic                         driveBoost,
   // serial outputs
   output logic                         outEnable_n,
   output logic                         data_bit_clock_out,
   output logic                         frame_clock_out,
   output logic [CHANNELS*2-1:0]        laneRise,
   output logic [CHANNELS*2-1:0]        laneFall
);
   afo_pkg::afo_power_t powerState;
   afo_pkg::afo_power_t next_powerState;
   logic        pdPinMeta;
   logic        pdPinSync;
   logic [7:0]  driveReg;
   logic [5:0]  relockCnt;
   logic [15:0] codeWord [CHANNELS];
   logic [15:0] txWord   [CHANNELS];
   logic        reqToggle;
   logic        ackMeta;
   logic        ackSync;
   // link domain
   logic        rstMeta;
   logic        linkReset_n;
   logic        reqMeta;
   logic        reqSync;
   logic        ackToggle;
   logic        oneMeta;
   logic        oneSync;
   logic        shortMeta;
   logic        shortSync;
   logic [3:0]  frameCnt;
   logic [3:0]  lastCnt;
   logic [3:0]  next_frameCnt;
   logic        load;
   logic        newWord;
   logic [15:0] linkWord [CHANNELS];
   logic [15:0] loadWord [CHANNELS];

   // power-down pin synchroniser
   always_ff @(posedge clk_sys) begin
      pdPinMeta <= power_down_pin;
      pdPinSync <= pdPinMeta;
   end

   // power mode selection, pin or command wins over standby
   always_comb begin
      next_powerState = powerState;
      case (powerState)
         afo_pkg::PWR_RUN,
         afo_pkg::PWR_STANDBY,
         afo_pkg::PWR_DOWN: begin
            if (pdPinSync || powerDownCmd) begin
               next_powerState = afo_pkg::PWR_DOWN;
            end else if (standbyCmd) begin
               next_powerState = afo_pkg::PWR_STANDBY;
            end else begin
               next_powerState = afo_pkg::PWR_RUN;
            end
         end
         default: next_powerState = afo_pkg::PWR_DOWN;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         powerState <= afo_pkg::PWR_DOWN;
      end else begin
         powerState <= next_powerState;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         outEnable_n <= 1'b1;
         convActive  <= 1'b0;
         refPowered  <= 1'b0;
      end else begin
         outEnable_n <= (next_powerState == afo_pkg::PWR_DOWN);
         convActive  <= (next_powerState == afo_pkg::PWR_RUN);
         refPowered  <= (next_powerState != afo_pkg::PWR_DOWN);
      end
   end

   // drive settings and stabilizer status
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         driveReg        <= afo_pkg::DRIVE_RESET;
         reducedSwing    <= 1'b0;
         dutyRegenActive <= 1'b0;
      end else begin
         if (regWrite && regAddr == afo_pkg::REG_DRIVE_OFFSET) begin
            driveReg <= regWrData;
         end
         reducedSwing    <= reducedSwingCmd;
         dutyRegenActive <= duty_cycle_stabilizer &&
            (SAMPLE_MHZ >= afo_pkg::DCS_MIN_MHZ);
      end
   end

   assign driveBoost = driveReg[afo_pkg::DRIVE_BOOST_BIT];

   // relock wait after a sample clock rate change
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         relockCnt <= '0;
      end else if (clockRateChange) begin
         relockCnt <= 6'(afo_pkg::RELOCK_CYCLES);
      end else if (relockCnt != '0) begin
         relockCnt <= relockCnt - 6'h1;
      end
   end

   assign dataSettling = (relockCnt != '0);

   always_comb begin
      regRdData = 8'h00;
      if (regAddr == afo_pkg::REG_DRIVE_OFFSET) begin
         regRdData = driveReg;
      end else if (regAddr == afo_pkg::REG_STATUS_OFFSET) begin
         regRdData[afo_pkg::STAT_PWR_DOWN_BIT] =
            (powerState == afo_pkg::PWR_DOWN);
         regRdData[afo_pkg::STAT_STANDBY_BIT] =
            (powerState == afo_pkg::PWR_STANDBY);
         regRdData[afo_pkg::STAT_DCS_BIT]    = dutyRegenActive;
         regRdData[afo_pkg::STAT_SETTLE_BIT] = dataSettling;
      end
   end

   // output coding and bit order per channel
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_code
         logic [15:0] coded;
         always_comb begin
            if (posOverrange[ch]) begin
               coded = offsetBinary ? afo_pkg::POS_SAT_OFFSET
                                    : afo_pkg::POS_SAT_TWOS;
            end else if (negOverrange[ch]) begin
               coded = offsetBinary ? afo_pkg::NEG_SAT_OFFSET
                                    : afo_pkg::NEG_SAT_TWOS;
            end else begin
               coded = {sampleIn[ch*14 +: 14], 2'b00};
               if (offsetBinary) begin
                  coded = coded ^ afo_pkg::SIGN_FLIP;
               end
            end
            codeWord[ch] = coded;
            if (lsbFirst && shortFrame) begin
               for (int b = 0; b < 12; b++) begin
                  codeWord[ch][15-b] = coded[4+b];
               end
            end else if (lsbFirst) begin
               for (int b = 0; b < 16; b++) begin
                  codeWord[ch][15-b] = coded[b];
               end
            end
         end

         // hand the same sample instant to the link side
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               txWord[ch] <= '0;
            end else if (convActive && reqToggle == ackSync) begin
               txWord[ch] <= codeWord[ch];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      ackMeta <= ackToggle;
      ackSync <= ackMeta;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         reqToggle <= 1'b0;
      end else if (convActive && reqToggle == ackSync) begin
         reqToggle <= ~reqToggle;
      end
   end

   // link domain synchronisers
   always_ff @(posedge clk_link) begin
      rstMeta     <= reset_n;
      linkReset_n <= rstMeta;
      reqMeta     <= reqToggle;
      reqSync     <= reqMeta;
      oneMeta     <= oneLaneMode;
      oneSync     <= oneMeta;
      shortMeta   <= shortFrame;
      shortSync   <= shortMeta;
   end

   // last count of a frame, cycles per frame minus one: bits / (lanes * 2) - 1
   always_comb begin
      if (oneSync) begin
         lastCnt = shortSync ? 4'h5 : 4'h7;
      end else begin
         lastCnt = shortSync ? 4'h2 : 4'h3;
      end
   end

   assign load          = (frameCnt >= lastCnt);
   assign newWord       = load && (reqSync != ackToggle);
   assign next_frameCnt = load ? 4'h0 : frameCnt + 4'h1;

   always_ff @(posedge clk_link) begin
      if (!linkReset_n) begin
         frameCnt        <= 4'hF;
         ackToggle       <= 1'b0;
         frame_clock_out <= 1'b0;
      end else begin
         frameCnt <= next_frameCnt;
         if (newWord) begin
            ackToggle <= ~ackToggle;
         end
         frame_clock_out <=
            (next_frameCnt < ((lastCnt + 4'h1) >> 1));
      end
   end

   // the link clock is forwarded as the data bit clock
   assign data_bit_clock_out = clk_link;

   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_lane
         always_comb begin
            loadWord[ch] = newWord ? txWord[ch] : linkWord[ch];
         end

         always_ff @(posedge clk_link) begin
            if (!linkReset_n) begin
               linkWord[ch] <= '0;
            end else if (load) begin
               linkWord[ch] <= loadWord[ch];
            end
         end

         afo_lane_shifter #(
            .WIDTH (16)
         ) u_first (
            .clk_link    (clk_link),
            .linkReset_n (linkReset_n),
            .load        (load),
            .loadWord    (loadWord[ch]),
            .riseBit     (laneRise[2*ch]),
            .fallBit     (laneFall[2*ch])
         );

         afo_lane_shifter #(
            .WIDTH (16)
         ) u_second (
            .clk_link    (clk_link),
            .linkReset_n (linkReset_n),
            .load        (load),
            .loadWord    (oneSync ? 16'h0000 :
                          shortSync ? loadWord[ch] << 6
                                    : loadWord[ch] << 8),
            .riseBit     (laneRise[2*ch+1]),
            .fallBit     (laneFall[2*ch+1])
         );
      end
   endgenerate

   // checks, sample clock domain
   pin_down_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      pdPinSync |=> powerState == afo_pkg::PWR_DOWN
   ) else $error("pin high did not power down");

   pin_release_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      !pdPinSync && !powerDownCmd && !standbyCmd
      |=> powerState == afo_pkg::PWR_RUN
   ) else $error("pin low did not resume");

   down_hiz_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (powerDownCmd || pdPinSync) |=> outEnable_n ##1 outEnable_n
         or !(powerDownCmd || pdPinSync)
   ) else $error("outputs driven while down");

   standby_ref_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      powerState == afo_pkg::PWR_STANDBY |-> refPowered && !convActive
   ) else $error("standby state wrong");

   zero_code_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      sampleIn[13:0] == 14'h0000 && !posOverrange[0]
         && !negOverrange[0] && !lsbFirst
      |-> codeWord[0] == (offsetBinary ? 16'h8000 : 16'h0000)
   ) else $error("zero code wrong");

   pos_sat_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      posOverrange[0] && !lsbFirst
      |-> codeWord[0] == (offsetBinary ? 16'hFFFC : 16'h7FFC)
   ) else $error("positive saturation wrong");

   drive_reg_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      regWrite && regAddr == 8'h15
      |=> driveBoost == $past(regWrData[0])
   ) else $error("drive setting not applied");

   relock_hold_a: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      clockRateChange |=> dataSettling [*8]
   ) else $error("relock wait too short");

   // checks, link clock domain
   frame_mark_a: assert property (
      @(posedge clk_link) disable iff (!linkReset_n)
      load |=> frame_clock_out && laneRise[0] == $past(loadWord[0][15])
   ) else $error("frame clock not at word start");

   frame_len_a: assert property (
      @(posedge clk_link) disable iff (!linkReset_n)
      load ##1 (!oneSync && !shortSync) [*4]
      |-> load && !$past(load, 1) && !$past(load, 2) && !$past(load, 3)
   ) else $error("two-lane frame not four cycles");

endmodule // afo_serial_framer
`default_nettype wire

// File: common/afo_pkg.sv
// constants and types shared by the serial output framer
// How it works
// - stabilizer on regenerates the falling edge for a 50% internal clock
// - stabilizer is inactive below about 20 MHz sample clock
// - power-down pin high or control-port command enters power-down
// - power-down pin low returns to normal operation
// - powered down, all data and clock outputs are high impedance
// - standby stops conversion but keeps the reference powered
// - drivers default to full swing; a setting selects reduced swing
// - drive register raises strength of all data outputs together
// - twos complement by default; a setting selects offset binary
// - zero, positive and negative saturation codes per coding
// - each channel on its own DDR lanes, two by default
// - bit clock runs at four times the sample rate by default
// - frame clock marks each new word at the sample rate
// - 14 sample bits then two zero pad bits; 12-bit option
// - MSB first by default; a setting gives LSB first
package afo_pkg;
   localparam logic [7:0]  REG_DRIVE_OFFSET  = 8'h15;
   localparam logic [7:0]  REG_STATUS_OFFSET = 8'h16;
   localparam logic [7:0]  DRIVE_RESET       = 8'h00;
   localparam int          DRIVE_BOOST_BIT   = 0;
   localparam int          STAT_PWR_DOWN_BIT = 0;
   localparam int          STAT_STANDBY_BIT  = 1;
   localparam int          STAT_DCS_BIT      = 2;
   localparam int          STAT_SETTLE_BIT   = 3;
   localparam int          SAMPLE_BITS       = 14;
   localparam int          FRAME_BITS        = 16;
   localparam int          SHORT_FRAME_BITS  = 12;
   localparam int          CHANNELS          = 4;
   localparam int          LANES_PER_CH      = 2;
   localparam logic [15:0] SIGN_FLIP         = 16'h8000;
   localparam logic [15:0] POS_SAT_OFFSET    = 16'hFFFC;
   localparam logic [15:0] POS_SAT_TWOS      = 16'h7FFC;
   localparam logic [15:0] NEG_SAT_OFFSET    = 16'h0000;
   localparam logic [15:0] NEG_SAT_TWOS      = 16'h8000;
   localparam int          CLK_SYS_MHZ       = 25;
   localparam int          DCS_MIN_MHZ       = 20;
   localparam int          RELOCK_NS         = 1500;
   localparam int          RELOCK_CYCLES     =
      (RELOCK_NS * CLK_SYS_MHZ + 999) / 1000;
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_STANDBY,
      PWR_DOWN
   } afo_power_t;
endpackage

// File: hdl/afo_lane_shifter.sv
// one DDR lane: two bits per link clock cycle, first bit on the rise
`timescale 1ns/1ps
`default_nettype none
module afo_lane_shifter #(
   parameter int WIDTH = 16
) (
   // link clock and reset
   input  wire logic             clk_link,
   input  wire logic             linkReset_n,
   // word load
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadWord,
   // lane bits
   output logic                  riseBit,
   output logic                  fallBit
);
   logic [WIDTH-1:0] shiftWord;

   always_ff @(posedge clk_link) begin
      if (!linkReset_n) begin
         shiftWord <= '0;
         riseBit   <= 1'b0;
         fallBit   <= 1'b0;
      end else if (load) begin
         shiftWord <= loadWord << 2;
         riseBit   <= loadWord[WIDTH-1];
         fallBit   <= loadWord[WIDTH-2];
      end else begin
         shiftWord <= shiftWord << 2;
         riseBit   <= shiftWord[WIDTH-1];
         fallBit   <= shiftWord[WIDTH-2];
      end
   end
endmodule // afo_lane_shifter
`default_nettype wire

// File: dv/afo_lane_receiver.sv
// lane receiver model: rebuilds words from one or two DDR lanes per channel
`timescale 1ns/1ps
`default_nettype none
module afo_lane_receiver #(
   parameter int CHANNELS = 4
) (
   // forwarded clocks
   input  wire logic                   bitClk,
   input  wire logic                   frameClk,
   // lanes and the lane count the receiver is set up for
   input  wire logic [CHANNELS*2-1:0]  laneRise,
   input  wire logic [CHANNELS*2-1:0]  laneFall,
   input  wire logic                   oneLane,
   // rebuilt words and length of the last frame in bit clocks
   output logic      [CHANNELS*16-1:0] word,
   output logic      [3:0]             frameLen
);
   logic [15:0] accFirst  [CHANNELS];
   logic [15:0] accSecond [CHANNELS];
   logic [3:0]  cnt;
   logic        prevFrame;
   int          gap;
   initial begin
      cnt = '0;
      prevFrame = 1'b0;
      word = '0;
      frameLen = '0;
   end
   // bits are taken mid-cycle, the rise bit ahead of the fall bit;
   // the first lane's bits of the last frame are left-aligned into the word, the second lane's follow them
   always @(negedge bitClk) begin
      gap = 16 - 2 * int'(cnt);
      if (frameClk && !prevFrame) begin
         frameLen <= cnt;
         cnt      <= 4'h1;
         for (int n = 0; n < CHANNELS; n++) begin
            if (oneLane)
               word[n*16 +: 16] <= accFirst[n] << gap;
            else
               word[n*16 +: 16] <= (accFirst[n] << gap) |
                  ((accSecond[n] << gap) >> (16 - gap));
         end
      end else begin
         cnt <= cnt + 4'h1;
      end
      prevFrame <= frameClk;
      for (int n = 0; n < CHANNELS; n++) begin
         accFirst[n]  <= {accFirst[n][13:0], laneRise[2*n], laneFall[2*n]};
         accSecond[n] <= {accSecond[n][13:0], laneRise[2*n+1],
                          laneFall[2*n+1]};
      end
   end
endmodule // afo_lane_receiver
`default_nettype wire

// File: dv/adc_serial_output_framer_tb.sv
// self-checking bench for the serial output framer
`timescale 1ns/1ps
`default_nettype none
module adc_serial_output_framer_tb;
   localparam int CH = afo_pkg::CHANNELS;
   logic clk_sys, reset_n, clk_link;
   logic [CH*14-1:0] sampleIn;
   logic [CH-1:0] posOverrange, negOverrange;
   logic power_down_pin, powerDownCmd, standbyCmd, offsetBinary;
   logic lsbFirst, shortFrame, oneLaneMode, reducedSwingCmd;
   logic duty_cycle_stabilizer, clockRateChange, regWrite;
   logic [7:0] regAddr, regWrData, regRdData;
   logic convActive, refPowered, dutyRegenActive, dataSettling;
   logic reducedSwing, driveBoost, outEnable_n;
   logic data_bit_clock_out, frame_clock_out;
   logic [CH*2-1:0] laneRise, laneFall;
   logic [CH*16-1:0] rxWord;
   logic [3:0] rxLen;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   integer seed;

   afo_serial_framer dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
      .clk_link(clk_link), .sampleIn(sampleIn),
      .posOverrange(posOverrange), .negOverrange(negOverrange),
      .power_down_pin(power_down_pin), .powerDownCmd(powerDownCmd),
      .standbyCmd(standbyCmd), .offsetBinary(offsetBinary),
      .lsbFirst(lsbFirst), .shortFrame(shortFrame),
      .oneLaneMode(oneLaneMode), .reducedSwingCmd(reducedSwingCmd),
      .duty_cycle_stabilizer(duty_cycle_stabilizer),
      .clockRateChange(clockRateChange), .regWrite(regWrite),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .convActive(convActive), .refPowered(refPowered),
      .dutyRegenActive(dutyRegenActive), .dataSettling(dataSettling),
      .reducedSwing(reducedSwing), .driveBoost(driveBoost),
      .outEnable_n(outEnable_n), .data_bit_clock_out(data_bit_clock_out),
      .frame_clock_out(frame_clock_out), .laneRise(laneRise),
      .laneFall(laneFall));

   afo_lane_receiver #(.CHANNELS(CH)) rx_u (.bitClk(data_bit_clock_out),
      .frameClk(frame_clock_out), .laneRise(laneRise),
      .laneFall(laneFall), .oneLane(oneLaneMode), .word(rxWord),
      .frameLen(rxLen));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #7;
      forever #16 clk_link = ~clk_link;
   end

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrite = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge clk_sys);
      regWrite = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      regAddr = a;
      #1;
      check({8'h00, regRdData}, {8'h00, e});
   endtask

   // coded frame in transmission order, first bit in bit 15
   function automatic logic [15:0] exp_word(logic [13:0] s, logic p,
         logic ng, logic ob, logic lsb, logic sh);
      logic [15:0] w;
      w = p ? 16'h7FFC : (ng ? 16'h8000 : {s, 2'b00});
      if (ob)
         w = w ^ 16'h8000;
      if (lsb && sh)
         w[15:4] = {<<{w[15:4]}};
      else if (lsb)
         w = {<<{w}};
      if (sh)
         w[3:0] = 4'h0;
      return w;
   endfunction

   // bit clocks per frame: two bits per lane per bit clock
   function automatic logic [3:0] exp_len(logic one, logic sh);
      int bits;
      bits = sh ? afo_pkg::SHORT_FRAME_BITS : afo_pkg::FRAME_BITS;
      return 4'(bits / (one ? 2 : 2 * afo_pkg::LANES_PER_CH));
   endfunction

   initial begin
      seed = 32'h3363;
      reset_n = 1'b0;
      sampleIn = '0;
      posOverrange = '0;
      negOverrange = '0;
      {power_down_pin, powerDownCmd, standbyCmd, offsetBinary} = 4'h0;
      {lsbFirst, shortFrame, oneLaneMode, reducedSwingCmd} = 4'h0;
      {duty_cycle_stabilizer, clockRateChange, regWrite} = 3'h0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      repeat (16) @(negedge clk_sys);
      check(outEnable_n, 1'b1);
      reset_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      check(outEnable_n, 1'b0);
      check(reducedSwing, 1'b0);
      rd(8'h15, 8'h00);
      wr(8'h15, 8'h01);
      check(driveBoost, 1'b1);
      rd(8'h15, 8'h01);
      wr(8'h33, 8'hFF);
      rd(8'h33, 8'h00);
      rd(8'h15, 8'h01);
      wr(8'h15, 8'h00);
      check(driveBoost, 1'b0);
      $display("register test done");

      // kinds: zero, positive and negative overrange, random sample;
      // from 8 on: bit order, frame length and lane count vary
      for (int i = 0; i < 16; i++) begin
         offsetBinary = i[0] ^ i[1];
         lsbFirst = (i >= 8) && i[0];
         shortFrame = (i >= 8) && i[1];
         oneLaneMode = (i >= 8) && i[2];
         for (int n = 0; n < CH; n++)
            sampleIn[n*14 +: 14] = (i[2:1] == 2'h0 && i < 8) ? 14'h0000
                                   : 14'($random(seed));
         posOverrange = (i[2:1] == 2'h1 && i < 8) ? '1 : '0;
         negOverrange = (i[2:1] == 2'h2 && i < 8) ? '1 : '0;
         repeat (48) @(negedge clk_sys);
         for (int n = 0; n < CH; n++)
            check(rxWord[n*16 +: 16], exp_word(sampleIn[n*14 +: 14],
               posOverrange[n], negOverrange[n], offsetBinary,
               lsbFirst, shortFrame));
         check({12'h000, rxLen},
            {12'h000, exp_len(oneLaneMode, shortFrame)});
      end
      {lsbFirst, shortFrame, oneLaneMode} = 3'h0;
      $display("coding test done");

      powerDownCmd = 1'b1;
      @(negedge clk_sys);
      check(outEnable_n, 1'b1);
      check({convActive, refPowered}, 2'b00);
      rd(8'h16, 8'h01);
      powerDownCmd = 1'b0;
      @(negedge clk_sys);
      check({outEnable_n, convActive}, 2'b01);
      standbyCmd = 1'b1;
      @(negedge clk_sys);
      check({convActive, refPowered}, 2'b01);
      rd(8'h16, 8'h02);
      standbyCmd = 1'b0;
      power_down_pin = 1'b1;
      repeat (3) @(negedge clk_sys);
      check(outEnable_n, 1'b1);
      power_down_pin = 1'b0;
      repeat (3) @(negedge clk_sys);
      check(outEnable_n, 1'b0);
      $display("power test done");

      reducedSwingCmd = 1'b1;
      duty_cycle_stabilizer = 1'b1;
      clockRateChange = 1'b1;
      @(negedge clk_sys);
      clockRateChange = 1'b0;
      @(negedge clk_sys);
      check(reducedSwing, 1'b1);
      check(dutyRegenActive, 1'b1);
      check(dataSettling, 1'b1);
      rd(8'h16, 8'h0C);
      repeat (40) @(negedge clk_sys);
      check(dataSettling, 1'b0);
      duty_cycle_stabilizer = 1'b0;
      repeat (2) @(negedge clk_sys);
      check(dutyRegenActive, 1'b0);
      $display("mode test done");
      finish_test();
   end
endmodule // adc_serial_output_framer_tb
`default_nettype wire
